// *** card_link_checker.sv ***
// Link protocol assertions between the record bank and its host controller
`timescale 1ns/1ps
module card_link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [card_record_pkg::ADDR_BITS-1:0] addr,
  input wire logic [card_record_pkg::WORD_BITS-1:0] wdata,
  input wire logic [card_record_pkg::WORD_BITS-1:0] rdata,
  input wire logic ack
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_take;
    req && !ack;
  endsequence
  // One-cycle answer, then the host lets go
  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence

  property p_take_answered;
    s_take |=> s_answer;
  endproperty
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  property p_no_spurious_ack;
    !req |=> !ack;
  endproperty
  property p_req_held;
    s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  property p_rdata_holds;
    ack |=> $stable(rdata);
  endproperty
  property p_addr_mapped;
    req |-> addr <= card_record_pkg::DRIVER_STAGE_WORD;
  endproperty
  // Only the tail is writable, with its fixed bits in place
  property p_write_tail_only;
    req && we |-> addr == card_record_pkg::TAIL_WORD && wdata[0] && wdata[9:8] == 2'h0;
  endproperty
  property p_tail_read_form;
    ack && addr == card_record_pkg::TAIL_WORD |-> rdata[0] && rdata[9:8] == 2'h0;
  endproperty

  a_take_answered: assert property (p_take_answered) else $error("link take not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("link ack longer than one cycle");
  a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("ack without request");
  a_req_held: assert property (p_req_held) else $error("request changed before ack");
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data not held");
  a_addr_mapped: assert property (p_addr_mapped) else $error("link address out of map");
  a_write_tail_only: assert property (p_write_tail_only) else $error("bad tail write");
  a_tail_read_form: assert property (p_tail_read_form) else $error("bad tail word read");
  c_tail_write: cover property (req && we);
endmodule : card_link_checker

// *** card_link_if.sv ***
// Word-wide link between the record bank and its host controller
`timescale 1ns/1ps
interface card_link_if;
  logic req;
  logic we;
  logic [card_record_pkg::ADDR_BITS-1:0] addr;
  logic [card_record_pkg::WORD_BITS-1:0] wdata;
  logic [card_record_pkg::WORD_BITS-1:0] rdata;
  logic ack;
  modport card (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : card_link_if

// *** card_record_bank.sv ***
// Card-side configuration record with writable tail and command gating
// Behaviour
// (RL1) Clock access part counts hundreds of cycles
// (RL2) Host sums async and clock latency parts
// (RL3) Rate unit codes 0-3, rest reserved
// (RL4) Rate multiplier table, code 0 reserved
// (RL5) Twelve-bit command class support mask
// (RL6) Read block length is power-of-two exponent
// (RL7) Write exponent always equals read exponent
// (RL8) Partial reads always allowed, flag one
// (RL9) Misalignment flags gate boundary crossing
// (RL10) Driver stage register exists only if flagged
// (RL11) Capacity from size, multiplier and block length
// (RL12) Size multiplier codes give factors 4..512
// (RL13) Single block erase only when flag set
// (RL14) Sector size is blocks minus one
// (RL15) Group size is sectors minus one
// (RL16) No group protection when enable clear
// (RL17) Program time factor codes 1..32
// (RL18) Partial writes only when flag set
// (RL19) Copy flag sticks once set
// (RL20) Permanent lock rejects writes and erases; code still accepts secure-area ones
// (RL21) Temporary lock rejects while set, clearable; code still accepts secure-area commands
// (RL22) Host rewrites checksum on every change
`timescale 1ns/1ps
module card_record_bank #(
  parameter logic [7:0] ASYNC_TIME_CODE = 8'h26,
  parameter logic [7:0] ACCESS_CLOCK_CYCLES = 8'h00,
  parameter logic [7:0] RATE_CODE = 8'h32,
  parameter logic [11:0] COMMAND_CLASS_MASK = 12'h5B5,
  parameter logic [3:0] READ_BLOCK_EXPONENT = 4'h9,
  parameter logic WRITE_CROSS_OK = 1'b0,
  parameter logic READ_CROSS_OK = 1'b0,
  parameter logic DRIVER_STAGE_PRESENT = 1'b0,
  parameter logic [11:0] SIZE_CODE = 12'hF03,
  parameter logic [11:0] CURRENT_CODES = 12'h8E4,
  parameter logic [2:0] CAPACITY_MULTIPLIER_CODE = 3'h4,
  parameter logic SINGLE_BLOCK_ERASE_OK = 1'b1,
  parameter logic [6:0] SECTOR_BLOCKS_CODE = 7'h1F,
  parameter logic [6:0] PROTECT_GROUP_SECTORS = 7'h7F,
  parameter logic GROUP_PROTECT_ENABLE = 1'b1,
  parameter logic [2:0] PROGRAM_TIME_FACTOR = 3'h4,
  parameter logic PARTIAL_WRITE_ALLOWED = 1'b0,
  parameter logic FORMAT_GROUP = 1'b0,
  parameter logic COPY_FLAG = 1'b1,
  parameter logic [1:0] FORMAT_CODE = 2'h0,
  parameter logic [15:0] DRIVER_STAGE_RESET = 16'h0404
) (
  input wire logic hclk,
  input wire logic hresetn,
  card_link_if.card link,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic cmd_write_erase,
  input wire logic cmd_secure_area,
  input wire logic cmd_single_block_erase,
  input wire logic cmd_group_protect,
  input wire logic cmd_partial_write,
  input wire logic cmd_crosses_boundary,
  output logic cmd_done,
  output logic cmd_accepted,
  output logic permanent_lock_bit,
  output logic temporary_lock_bit,
  output logic copy_flag,
  output logic [15:0] driver_stage_value,
  output logic [11:0] command_class_mask,
  output logic [32:0] capacity_bytes,
  output logic [11:0] read_block_bytes,
  output logic [7:0] erase_sector_blocks,
  output logic [7:0] protect_group_sectors,
  output logic [5:0] program_time_multiple,
  output logic [15:0] access_clock_cycles,
  output logic [23:0] rate_kbit_x10
);
  localparam int WB = card_record_pkg::WORD_BITS;

  // Constant head of the record; write exponent mirrors the read one
  localparam logic [card_record_pkg::REC_BITS-1:WB] REC_HI = {
    card_record_pkg::RECORD_VERSION, 6'h00, ASYNC_TIME_CODE, ACCESS_CLOCK_CYCLES,
    RATE_CODE, COMMAND_CLASS_MASK, READ_BLOCK_EXPONENT, 1'b1, WRITE_CROSS_OK,
    READ_CROSS_OK, DRIVER_STAGE_PRESENT, 2'h0, SIZE_CODE, CURRENT_CODES,
    CAPACITY_MULTIPLIER_CODE, SINGLE_BLOCK_ERASE_OK, SECTOR_BLOCKS_CODE,
    PROTECT_GROUP_SECTORS, GROUP_PROTECT_ENABLE, 2'h0, PROGRAM_TIME_FACTOR,
    READ_BLOCK_EXPONENT, PARTIAL_WRITE_ALLOWED, 5'h00}; // see (RL5) (RL6) (RL7) (RL8)
  localparam logic [7:0] FACTORY_BYTE = {FORMAT_GROUP, COPY_FLAG, 1'b0, 1'b0,
                                         FORMAT_CODE, 2'h0}; // see (RL20) (RL21)
  localparam logic [WB-1:0] FACTORY_TAIL = {FACTORY_BYTE,
      card_record_pkg::crc7({REC_HI, FACTORY_BYTE}), 1'b1};

  typedef struct packed {
    logic ack;
    logic [WB-1:0] rdata;
    logic [WB-1:0] tail;
    logic [WB-1:0] driver_stage;
    logic done;
    logic accepted;
  } bank_state_t;

  bank_state_t st_ff;
  bank_state_t nxt_st;
  logic [card_record_pkg::REC_BITS-1:0] record;
  logic locked;
  logic reject;

  assign record = {REC_HI, st_ff.tail};
  assign locked = st_ff.tail[card_record_pkg::PERM_BIT] | st_ff.tail[card_record_pkg::TMP_BIT];

  always_comb begin
    reject = 1'b0;
    if (cmd_write_erase && !cmd_secure_area && locked) begin
      reject = 1'b1; // see (RL20) (RL21)
    end
    if (cmd_single_block_erase && !SINGLE_BLOCK_ERASE_OK) begin
      reject = 1'b1; // see (RL13)
    end
    if (cmd_group_protect && !GROUP_PROTECT_ENABLE) begin
      reject = 1'b1; // see (RL16)
    end
    if (!cmd_is_read && cmd_partial_write && !PARTIAL_WRITE_ALLOWED) begin
      reject = 1'b1; // see (RL18)
    end
    if (cmd_crosses_boundary && (cmd_is_read ? !READ_CROSS_OK : !WRITE_CROSS_OK)) begin
      reject = 1'b1; // see (RL9)
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.done = cmd_valid;
    if (cmd_valid) begin
      nxt_st.accepted = !reject;
    end
    // The ack cycle itself is skipped so a held request is taken once
    if (link.req && !st_ff.ack) begin
      nxt_st.ack = 1'b1;
      if (link.addr == card_record_pkg::DRIVER_STAGE_WORD) begin
        nxt_st.rdata = DRIVER_STAGE_PRESENT ? st_ff.driver_stage : '0; // see (RL10)
        if (link.we && DRIVER_STAGE_PRESENT) begin
          nxt_st.driver_stage = link.wdata; // see (RL10)
        end
      end else if (link.addr <= card_record_pkg::LAST_WORD) begin
        nxt_st.rdata = record[link.addr[2:0]*WB +: WB];
      end else begin
        nxt_st.rdata = '0;
      end
      if (link.we && link.addr == card_record_pkg::TAIL_WORD) begin
        nxt_st.tail = link.wdata;
        nxt_st.tail[card_record_pkg::COPY_BIT] = link.wdata[card_record_pkg::COPY_BIT]
            | st_ff.tail[card_record_pkg::COPY_BIT]; // see (RL19)
        nxt_st.tail[card_record_pkg::PERM_BIT] = link.wdata[card_record_pkg::PERM_BIT]
            | st_ff.tail[card_record_pkg::PERM_BIT]; // see (RL20)
        nxt_st.tail[card_record_pkg::RSV_LSB +: 2] = 2'h0;
        nxt_st.tail[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{ack: 1'b0, rdata: '0, tail: FACTORY_TAIL,
                 driver_stage: DRIVER_STAGE_RESET, done: 1'b0, accepted: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.ack = st_ff.ack;
  assign link.rdata = st_ff.rdata;
  assign cmd_done = st_ff.done;
  assign cmd_accepted = st_ff.accepted;
  assign permanent_lock_bit = st_ff.tail[card_record_pkg::PERM_BIT];
  assign temporary_lock_bit = st_ff.tail[card_record_pkg::TMP_BIT];
  assign copy_flag = st_ff.tail[card_record_pkg::COPY_BIT];
  assign driver_stage_value = DRIVER_STAGE_PRESENT ? st_ff.driver_stage : '0;
  assign command_class_mask = COMMAND_CLASS_MASK; // see (RL5)

  // Decoded views of the fixed fields, constant per build
  localparam logic [32:0] CAPACITY = 33'((34'(SIZE_CODE) + 34'h1)
      << (4'(CAPACITY_MULTIPLIER_CODE) + 4'(card_record_pkg::MULT_BASE))
      << READ_BLOCK_EXPONENT); // see (RL11) (RL12)
  assign capacity_bytes = CAPACITY;
  assign read_block_bytes = 12'(13'h1 << READ_BLOCK_EXPONENT); // see (RL6)
  assign erase_sector_blocks = 8'(SECTOR_BLOCKS_CODE) + 8'h01; // see (RL14)
  assign protect_group_sectors = 8'(PROTECT_GROUP_SECTORS) + 8'h01; // see (RL15)
  // Codes 6 and 7 are reserved and read as zero
  assign program_time_multiple = (PROGRAM_TIME_FACTOR > 3'h5) ? 6'h00
      : 6'(7'h01 << PROGRAM_TIME_FACTOR); // see (RL17)
  assign access_clock_cycles = 16'(ACCESS_CLOCK_CYCLES * card_record_pkg::ACCESS_CYCLE_UNIT); // see (RL1)

  always_comb begin
    logic [16:0] unit_kbit;
    unit_kbit = 17'h00000;
    case (RATE_CODE[2:0])
      3'h0: unit_kbit = 17'h00064;
      3'h1: unit_kbit = 17'h003E8;
      3'h2: unit_kbit = 17'h02710;
      3'h3: unit_kbit = 17'h186A0;
      default: unit_kbit = 17'h00000; // see (RL3)
    endcase
    // Widen before the product; 100 Mbit/s times 8.0 needs 23 bits
    rate_kbit_x10 = 24'(unit_kbit) * 24'(card_record_pkg::mant10(RATE_CODE[6:3])); // see (RL4)
  end
endmodule : card_record_bank

// *** card_record_host.sv ***
// Host controller: AHB-Lite registers, record cache, checksum and derived sizes
`timescale 1ns/1ps
module card_record_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  card_link_if.host link
);
  typedef enum {IDLE, LOAD, WRITE} host_mode_t;
  typedef struct packed {
    host_mode_t mode;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [7:0] tail_byte;
    logic [127:0] rec;
    logic [3:0] idx;
    logic req;
    logic we;
    logic [15:0] wdata;
    logic done;
  } host_state_t;

  host_state_t st_ff;
  host_state_t nxt_st;
  logic [32:0] capacity;
  logic [31:0] latency;
  logic [7:0] erase_unit;
  logic [15:0] new_tail;
  localparam logic [7:0] STICKY_MASK =
      (8'h01 << (card_record_pkg::COPY_BIT - card_record_pkg::TAIL_BYTE_LSB))
      | (8'h01 << (card_record_pkg::PERM_BIT - card_record_pkg::TAIL_BYTE_LSB));

  function automatic logic [31:0] pow10(input logic [2:0] e);
    logic [31:0] p;
    p = 32'h1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(e)) begin
        p = 32'(p * 32'hA);
      end
    end
    return p;
  endfunction : pow10

  always_comb begin
    logic [7:0] async_code;
    logic [31:0] tenths;
    logic [7:0] merged;
    async_code = st_ff.rec[card_record_pkg::ASYNC_TIME_LSB +: 8];
    tenths = '0;
    merged = '0;
    capacity = 33'((34'(st_ff.rec[card_record_pkg::CSIZE_LSB +: 12]) + 34'h1)
        << (4'(st_ff.rec[card_record_pkg::MULT_LSB +: 3]) + 4'(card_record_pkg::MULT_BASE))
        << st_ff.rec[card_record_pkg::RBL_LSB +: 4]); // see (RL11)
    // Async part in tenths of ns rounded up to whole cycles
    tenths = 32'(card_record_pkg::mant10(async_code[6:3]) * pow10(async_code[2:0]));
    latency = 32'(st_ff.rec[card_record_pkg::CLOCK_CYCLES_LSB +: 8]
        * card_record_pkg::ACCESS_CYCLE_UNIT)
        + 32'((tenths + 32'(card_record_pkg::CLK_PERIOD_TENTHS - 1))
        / 32'(card_record_pkg::CLK_PERIOD_TENTHS)); // see (RL2)
    erase_unit = st_ff.rec[card_record_pkg::EBLK_BIT] ? 8'h01
        : 8'(st_ff.rec[card_record_pkg::SECTOR_LSB +: 7]) + 8'h01; // see (RL13)
    // Checksum must cover what the card keeps: sticky bits stay, reserved bits clear
    // Limitation: sticky bits are only known after a load
    merged = st_ff.tail_byte | (st_ff.rec[card_record_pkg::TAIL_BYTE_LSB +: 8] & STICKY_MASK);
    merged[card_record_pkg::RSV_LSB - card_record_pkg::TAIL_BYTE_LSB +: 2] = 2'h0;
    new_tail = {merged,
        card_record_pkg::crc7({st_ff.rec[127:16], merged}), 1'b1}; // see (RL22)
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.a_valid = hsel && hready && htrans[1];
    if (hready) begin
      nxt_st.a_write = hwrite;
      nxt_st.a_addr = haddr[7:0];
    end else begin
      nxt_st.a_valid = st_ff.a_valid;
    end
    if (st_ff.a_valid && st_ff.a_write) begin
      if (st_ff.a_addr == card_record_pkg::TAIL_OFS) begin
        nxt_st.tail_byte = hwdata[7:0];
      end
      if (st_ff.a_addr == card_record_pkg::CTRL_OFS && st_ff.mode == IDLE) begin
        if (hwdata[card_record_pkg::CTRL_LOAD_BIT]) begin
          nxt_st.mode = LOAD;
          nxt_st.idx = card_record_pkg::TAIL_WORD;
          nxt_st.done = 1'b0;
        end else if (hwdata[card_record_pkg::CTRL_WRITE_BIT]) begin
          nxt_st.mode = WRITE;
          nxt_st.done = 1'b0;
        end
      end
    end
    case (st_ff.mode)
      IDLE: begin
        nxt_st.req = 1'b0;
      end
      LOAD: begin
        nxt_st.req = !link.ack;
        nxt_st.we = 1'b0;
        nxt_st.wdata = '0;
        if (link.ack && st_ff.req) begin
          nxt_st.rec[st_ff.idx[2:0]*16 +: 16] = link.rdata;
          nxt_st.idx = st_ff.idx + 4'h1;
          if (st_ff.idx == card_record_pkg::LAST_WORD) begin
            nxt_st.mode = IDLE;
            nxt_st.done = 1'b1;
            nxt_st.req = 1'b0;
          end
        end
      end
      WRITE: begin
        nxt_st.req = !link.ack;
        nxt_st.we = 1'b1;
        nxt_st.wdata = new_tail;
        nxt_st.idx = card_record_pkg::TAIL_WORD;
        // Reload so the cache shows the sticky bits the card kept
        if (link.ack && st_ff.req) begin
          nxt_st.mode = LOAD;
          nxt_st.we = 1'b0;
          nxt_st.req = 1'b0;
        end
      end
      default: begin
        nxt_st.mode = IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{mode: IDLE, a_valid: 1'b0, a_write: 1'b0, a_addr: '0, tail_byte: '0,
                 rec: '0, idx: '0, req: 1'b0, we: 1'b0, wdata: '0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    hrdata = 32'h00000000;
    if (st_ff.a_valid && !st_ff.a_write) begin
      case (st_ff.a_addr)
        card_record_pkg::TAIL_OFS: hrdata = {24'h000000, st_ff.tail_byte};
        card_record_pkg::STATUS_OFS: hrdata = {30'h0, st_ff.done, st_ff.mode != IDLE};
        card_record_pkg::REC0_OFS: hrdata = st_ff.rec[31:0];
        card_record_pkg::REC1_OFS: hrdata = st_ff.rec[63:32];
        card_record_pkg::REC2_OFS: hrdata = st_ff.rec[95:64];
        card_record_pkg::REC3_OFS: hrdata = st_ff.rec[127:96];
        card_record_pkg::CAP_LO_OFS: hrdata = capacity[31:0];
        card_record_pkg::CAP_HI_OFS: hrdata = {31'h0, capacity[32]};
        card_record_pkg::LATENCY_OFS: hrdata = latency;
        card_record_pkg::ERASE_UNIT_OFS: hrdata = {24'h000000, erase_unit};
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign link.req = st_ff.req;
  assign link.we = st_ff.we;
  assign link.addr = st_ff.idx;
  assign link.wdata = st_ff.wdata;
endmodule : card_record_host

// *** card_record_pkg.sv ***
// Shared constants, field layout and helper functions for the card record link
package card_record_pkg;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam int WORD_COUNT = 8;
  localparam int REC_BITS = WORD_BITS * WORD_COUNT;
  localparam logic [ADDR_BITS-1:0] TAIL_WORD = 4'h0;
  localparam logic [ADDR_BITS-1:0] LAST_WORD = 4'h7;
  localparam logic [ADDR_BITS-1:0] DRIVER_STAGE_WORD = 4'h8;
  localparam logic [1:0] RECORD_VERSION = 2'h0;
  // Field positions inside the 128-bit record
  localparam int ASYNC_TIME_LSB = 112;
  localparam int CLOCK_CYCLES_LSB = 104;
  localparam int RATE_LSB = 96;
  localparam int RBL_LSB = 80;
  localparam int CSIZE_LSB = 62;
  localparam int MULT_LSB = 47;
  localparam int EBLK_BIT = 46;
  localparam int SECTOR_LSB = 39;
  localparam int CRC_LSB = 1;
  // Positions inside the writable tail word
  localparam int COPY_BIT = 14;
  localparam int PERM_BIT = 13;
  localparam int TMP_BIT = 12;
  localparam int RSV_LSB = 8;
  localparam int TAIL_BYTE_LSB = 8;
  localparam logic [6:0] CRC_POLY = 7'h09;
  // Timing
  localparam int ACCESS_CYCLE_UNIT = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_PERIOD_TENTHS = CLK_PERIOD_NS * 10;
  localparam int MULT_BASE = 2;
  // Host register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TAIL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] REC0_OFS = 8'h0C;
  localparam logic [7:0] REC1_OFS = 8'h10;
  localparam logic [7:0] REC2_OFS = 8'h14;
  localparam logic [7:0] REC3_OFS = 8'h18;
  localparam logic [7:0] CAP_LO_OFS = 8'h1C;
  localparam logic [7:0] CAP_HI_OFS = 8'h20;
  localparam logic [7:0] LATENCY_OFS = 8'h24;
  localparam logic [7:0] ERASE_UNIT_OFS = 8'h28;
  localparam int CTRL_LOAD_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;

  // Ten times the 1.0..8.0 mantissa; code 0 is reserved
  function automatic logic [6:0] mant10(input logic [3:0] code);
    logic [6:0] t [16];
    t = '{7'h00, 7'h0A, 7'h0C, 7'h0D, 7'h0F, 7'h14, 7'h19, 7'h1E,
          7'h23, 7'h28, 7'h2D, 7'h32, 7'h37, 7'h3C, 7'h46, 7'h50};
    return t[code];
  endfunction : mant10

  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = c[6] ^ d[i];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc7
endpackage : card_record_pkg

// *** tb.sv ***
// Testbench joining the record bank and its host controller
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [6:0] cmd = 7'h00;
  logic cmd_valid = 1'b0;
  logic cmd_done, cmd_accepted, perm, tmp, copy;
  logic [15:0] dsv, acc;
  logic [11:0] class_mask, rbb;
  logic [32:0] cap;
  logic [7:0] esb, pgs;
  logic [5:0] ptm;
  logic [23:0] rate;
  logic [127:0] rec;
  logic [31:0] rd;
  int miscompares = 0;
  int checked = 0;
  // Command qualifiers: read, write_erase, secure, single, group, partial, crosses
  logic [6:0] cv [8] = '{7'h20, 7'h08, 7'h04, 7'h02, 7'h42, 7'h41, 7'h01, 7'h40};
  logic ca [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  card_link_if link ();
  card_record_bank card_record_bank_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_is_read(cmd[6]), .cmd_write_erase(cmd[5]),
    .cmd_secure_area(cmd[4]), .cmd_single_block_erase(cmd[3]), .cmd_group_protect(cmd[2]),
    .cmd_partial_write(cmd[1]), .cmd_crosses_boundary(cmd[0]), .cmd_done(cmd_done),
    .cmd_accepted(cmd_accepted), .permanent_lock_bit(perm), .temporary_lock_bit(tmp),
    .copy_flag(copy), .driver_stage_value(dsv), .command_class_mask(class_mask),
    .capacity_bytes(cap), .read_block_bytes(rbb), .erase_sector_blocks(esb),
    .protect_group_sectors(pgs), .program_time_multiple(ptm), .access_clock_cycles(acc),
    .rate_kbit_x10(rate));
  card_record_host card_record_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  card_link_checker card_link_checker_inst (.hclk(hclk), .hresetn(hresetn), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Independent checksum model, msb first
  function automatic logic [6:0] crc_ref(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc_ref

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        miscompares++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  task automatic run_ctrl(input logic [31:0] v);
    int n;
    n = 0;
    ahb(1'b1, card_record_pkg::CTRL_OFS, v);
    ahb(1'b0, card_record_pkg::STATUS_OFS, 32'h0);
    while (rd[1:0] !== 2'h2) begin
      n++;
      if (n > 200) begin
        miscompares++;
        print_verdict();
      end
      ahb(1'b0, card_record_pkg::STATUS_OFS, 32'h0);
    end
  endtask : run_ctrl

  // Tail byte is record bits 15:8; the host refreshes the checksum
  task automatic set_tail(input logic [7:0] b, input logic [7:0] exp_b);
    ahb(1'b1, card_record_pkg::TAIL_OFS, {24'h0, b});
    run_ctrl(32'h2);
    ahb(1'b0, card_record_pkg::REC0_OFS, 32'h0);
    check(rd[15:0], {exp_b, crc_ref({rec[127:16], exp_b}), 1'b1});
  endtask : set_tail

  task automatic do_cmd(input logic [6:0] c, input logic exp);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge hclk);
    cmd_valid <= 1'b0;
    @(posedge hclk);
    check(cmd_done, 1'b1);
    check(cmd_accepted, exp);
  endtask : do_cmd

  initial begin
    rec = {2'h0, 6'h0, 8'h26, 8'h00, 8'h32, 12'h5B5, 4'h9, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0,
      12'hF03, 12'h8E4, 3'h4, 1'b1, 7'h1F, 7'h7F, 1'b1, 2'h0, 3'h4, 4'h9, 1'b0, 5'h0,
      8'h40, 7'h00, 1'b1};
    rec[7:1] = crc_ref(rec[127:8]);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(dsv, 16'h0000);
    check(class_mask, 12'h5B5);
    check(rbb, 12'h200);
    check(esb, 8'h20);
    check(pgs, 8'h80);
    check(ptm, 6'h10);
    check(acc, 16'h0000);
    // 2.5 times 10 Mbit/s, in tenths of kbit/s
    check(rate, 24'h03D090);
    check(cap, 33'((12'hF03 + 1) * (2 ** (3'h4 + 2)) * (2 ** 9)));
    run_ctrl(32'h1);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, card_record_pkg::REC0_OFS + 8'(4 * i), 32'h0);
      check(rd, rec[32 * i +: 32]);
    end
    ahb(1'b0, card_record_pkg::CAP_LO_OFS, 32'h0);
    check(rd, 32'((12'hF03 + 1) * (2 ** (3'h4 + 2)) * (2 ** 9)));
    ahb(1'b0, card_record_pkg::CAP_HI_OFS, 32'h0);
    check(rd, 32'h0);
    // 1.5 ms of asynchronous delay at 25 ns a cycle
    ahb(1'b0, card_record_pkg::LATENCY_OFS, 32'h0);
    check(rd, 32'h0000EA60);
    ahb(1'b0, card_record_pkg::ERASE_UNIT_OFS, 32'h0);
    check(rd, 32'h1);
    ahb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      do_cmd(cv[i], ca[i]);
    end
    set_tail(8'h10, 8'h50);
    check(tmp, 1'b1);
    do_cmd(7'h20, 1'b0);
    do_cmd(7'h30, 1'b1);
    set_tail(8'h00, 8'h40);
    check(tmp, 1'b0);
    check(copy, 1'b1);
    do_cmd(7'h20, 1'b1);
    set_tail(8'h20, 8'h60);
    do_cmd(7'h20, 1'b0);
    set_tail(8'h00, 8'h60);
    check(perm, 1'b1);
    do_cmd(7'h30, 1'b1);
    print_verdict();
  end
endmodule : tb
